// ===== wcf_crc8.sv
/*
 * checksum engine: x^8+x^2+x+1 over a 72-bit tree input, bit 0 first.
 * assumes: one request at a time; result registered, valid the next cycle.
 */
`include "wcf_regs.svh"

module wcf_crc8 (
  input  wire logic  mclk_i,  // clock
  input  wire logic  rst_n_i, // async reset, low
  wcf_crc_if.engine  crc_if   // request and answer
);
  import wcf_pkg::*;

  typedef struct packed {
    logic     done;
    wcf_crc_t crc;
  } wcf_crc_s;

  wcf_crc_s s_q;
  wcf_crc_s s_d;

  function automatic wcf_crc_t wcf_crc_calc(input wcf_word_t d);
    wcf_crc_t c;
    logic     fb;
    c = '0;
    for (int i = 0; i < 72; i++) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ `WCF_CRC_POLY;
      end
    end
    return c;
  endfunction : wcf_crc_calc

  always_comb begin
    s_d      = s_q;
    s_d.done = crc_if.req;
    if (crc_if.req) begin
      s_d.crc = wcf_crc_calc(crc_if.word);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign crc_if.done = s_q.done;
  assign crc_if.crc  = s_q.crc;

  a_crc_done_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    crc_if.req |=> crc_if.done && crc_if.crc == wcf_crc_calc($past(crc_if.word)))
    else $error("checksum answer missing or wrong");
endmodule : wcf_crc8

// ===== wcf_crc_if.sv
/*
 * request and answer between the framer and its checksum engine.
 * assumes: both ends share one clock; answer comes one cycle after request.
 */
interface wcf_crc_if;
  import wcf_pkg::*;
  logic      req;
  wcf_word_t word;
  logic      done;
  wcf_crc_t  crc;

  modport requester (output req, output word, input done, input crc);
  modport engine    (input req, input word, output done, output crc);
endinterface : wcf_crc_if

// ===== wcf_framer.sv
/*
 * write checksum framer: receives write frames on the data lanes, rebuilds
 * the checksum tree input, checks the checksum and raises an alert pulse.
 * assumes: one transfer per clock, inputs synchronous to mclk_i, two idle
 * cycles between checked frames, register port strobes one cycle long.
 */
// What this block does
// - checksum covers chopped and full writes only
// - checksum switched by a control register bit
// - checked frames are always ten transfers
// - burst length chosen per frame when enabled
// - x4 chopped: sixteen data bits, rest ones
// - upper half data feeds lower tree inputs
// - x8 chopped: 36 inputs, transfers 4-7 ones
// - lower half mask lane used when enabled
// - upper half mask lane used when enabled
// - mismatch drives alert low six clocks
// - mismatch sets sticky bit and page status
`include "wcf_regs.svh"

module wcf_framer (
  input  wire logic             mclk_i,              // 40 MHz clock
  input  wire logic             rst_n_i,             // async reset, low
  input  wire logic             beat_valid_i,        // one transfer this cycle
  input  wire logic             frame_start_i,       // transfer 0 of a frame
  input  wire logic [7:0]       dq_i,                // data lanes
  input  wire logic             mask_inv_lane_n_i,   // mask/inversion lane
  input  wire logic             burst_chop_four_i,   // chopped burst, at start
  input  wire logic             burst_half_select_i, // upper half, at start
  output      logic             alert_n_o,           // alert drive value
  output      logic             alert_oe_o,          // alert driven low
  output      wcf_pkg::wcf_word_t wr_data_o,         // received code word
  output      logic             wr_valid_o,          // frame received pulse
  input  wire wcf_pkg::wcf_addr_t reg_addr_i,        // register address
  input  wire wcf_pkg::wcf_data_t reg_wdata_i,       // register write data
  input  wire logic             reg_wr_i,            // write strobe
  input  wire logic             reg_rd_i,            // read strobe
  output      wcf_pkg::wcf_data_t reg_rdata_o,       // read data, next cycle
  output      logic             irq_o                // level interrupt
);
  import wcf_pkg::*;

  // ========================================================================
  // state
  typedef struct packed {
    wcf_state_e st;
    logic [3:0] beat;
    logic       chop;
    logic       half;
    wcf_word_t  buf_w;
    wcf_crc_t   rx_crc;
    wcf_crc_t   calc_crc;
    logic [2:0] ctrl;
    logic       err_clr;
    logic       page_err;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [7:0] err_cnt;
    logic [3:0] alert_cnt;
    wcf_word_t  wr_data;
    logic       wr_valid;
    wcf_data_t  rdata;
  } wcf_framer_s;

  wcf_framer_s s_q;
  wcf_framer_s s_d;
  wcf_crc_if   crc_if ();

  wcf_crc8 u_crc (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .crc_if  (crc_if)
  );

  // ========================================================================
  // helpers
  function automatic logic [3:0] wcf_last_beat(input logic crc_en, input logic chop);
    if (crc_en) begin
      return 4'(`WCF_FRAME_UI - 1);
    end
    return chop ? 4'(`WCF_CHOP_BEATS - 1) : 4'(`WCF_FULL_BEATS - 1);
  endfunction : wcf_last_beat

  // lane l, transfer t sits at bit l*8+t; lane 8 is the mask/inversion lane
  function automatic wcf_word_t wcf_tree(input wcf_word_t w, input logic x8,
                                         input logic chop, input logic mi_en);
    wcf_word_t t;
    t = w;
    if (chop) begin
      // upper-half data already arrives in transfers 0..3 and so lands on
      // tree inputs 3..0 of each lane; the other nibble is padding
      for (int l = 0; l < 9; l++) begin
        t[l*8 + 4 +: 4] = 4'hf;
      end
    end
    if (!mi_en) begin
      t[71:64] = 8'hff;
    end
    if (!x8) begin
      t[71:32] = '1;
    end
    return t;
  endfunction : wcf_tree

  function automatic logic wcf_hit(input wcf_addr_t a, input wcf_addr_t off);
    return a == off;
  endfunction : wcf_hit

  // ========================================================================
  // next state
  logic [3:0] last_beat;
  logic       crc_en;
  logic       x8;
  logic       mi_en;
  logic       err_ev;
  logic       frame_ev;

  assign crc_en = s_q.ctrl[`WCF_CTRL_CRC_EN];
  assign x8     = s_q.ctrl[`WCF_CTRL_ORG_X8];
  assign mi_en  = s_q.ctrl[`WCF_CTRL_MI_EN];

  always_comb begin
    s_d       = s_q;
    last_beat = wcf_last_beat(crc_en, s_q.chop);
    err_ev    = 1'b0;
    frame_ev  = 1'b0;
    crc_if.req  = 1'b0;
    crc_if.word = wcf_tree(s_q.buf_w, x8, s_q.chop, mi_en);
    s_d.wr_valid = 1'b0;
    s_d.rdata    = '0;

    case (s_q.st)
      WCF_IDLE: begin
        if (beat_valid_i && frame_start_i) begin
          s_d.chop  = burst_chop_four_i;
          s_d.half  = burst_half_select_i;
          s_d.buf_w = '1;
          for (int l = 0; l < 8; l++) begin
            s_d.buf_w[l*8] = dq_i[l];
          end
          s_d.buf_w[64] = mask_inv_lane_n_i;
          s_d.beat      = 4'h1;
          s_d.st        = WCF_RECV;
        end
      end
      WCF_RECV: begin
        if (beat_valid_i) begin
          s_d.beat = s_q.beat + 4'h1;
          if (s_q.beat < 4'(`WCF_FULL_BEATS)) begin
            for (int l = 0; l < 8; l++) begin
              s_d.buf_w[l*8 + 32'(s_q.beat)] = dq_i[l];
            end
            s_d.buf_w[64 + 32'(s_q.beat)] = mask_inv_lane_n_i;
          end else if (s_q.beat == 4'(`WCF_FULL_BEATS)) begin
            s_d.rx_crc = x8 ? dq_i : {s_q.rx_crc[7:4], dq_i[3:0]};
          end else begin
            s_d.rx_crc[7:4] = x8 ? s_q.rx_crc[7:4] : dq_i[3:0];
          end
          if (s_q.beat == last_beat) begin
            s_d.wr_data  = wcf_tree(s_d.buf_w, 1'b1, s_q.chop, mi_en);
            s_d.wr_valid = 1'b1;
            frame_ev     = 1'b1;
            if (crc_en) begin
              s_d.st = WCF_CHECK;
            end else begin
              s_d.st = WCF_IDLE;
            end
          end
        end
      end
      WCF_CHECK: begin
        // tree snapshot is complete now; engine answers next cycle
        if (!crc_if.done) begin
          crc_if.req = 1'b1;
        end else begin
          s_d.calc_crc = crc_if.crc;
          err_ev       = crc_if.crc != s_q.rx_crc;
          s_d.st       = WCF_IDLE;
        end
      end
      default: begin
        s_d.st = WCF_IDLE;
      end
    endcase

    if (err_ev) begin
      s_d.alert_cnt = 4'(`WCF_ALERT_PW_CLK);
    end else if (s_q.alert_cnt != 4'h0) begin
      s_d.alert_cnt = s_q.alert_cnt - 4'h1;
    end

    // register writes; hardware set wins over a clear in the same cycle
    if (reg_wr_i) begin
      if (wcf_hit(reg_addr_i, `WCF_OFF_CTRL)) begin
        s_d.ctrl = reg_wdata_i[2:0];
      end
      if (wcf_hit(reg_addr_i, `WCF_OFF_MODE5) && !reg_wdata_i[`WCF_MODE5_ERR_CLR]) begin
        s_d.err_clr  = 1'b0;
        s_d.page_err = 1'b0;
      end
      if (wcf_hit(reg_addr_i, `WCF_OFF_INT_STAT)) begin
        s_d.int_stat = s_q.int_stat & ~reg_wdata_i[1:0];
      end
      if (wcf_hit(reg_addr_i, `WCF_OFF_INT_MASK)) begin
        s_d.int_mask = reg_wdata_i[1:0];
      end
      if (wcf_hit(reg_addr_i, `WCF_OFF_ERR_CNT)) begin
        s_d.err_cnt = 8'h00;
      end
    end
    if (err_ev) begin
      s_d.err_clr  = 1'b1;
      s_d.page_err = 1'b1;
      s_d.err_cnt  = s_q.err_cnt + 8'h01;
      s_d.int_stat[`WCF_INT_CRC_ERR] = 1'b1;
    end
    if (frame_ev) begin
      s_d.int_stat[`WCF_INT_FRAME] = 1'b1;
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        `WCF_OFF_CTRL:     s_d.rdata = {29'h0, s_q.ctrl};
        `WCF_OFF_MODE5:    s_d.rdata = {28'h0, s_q.err_clr, 3'h0};
        `WCF_OFF_PAGE3:    s_d.rdata = {31'h0, s_q.page_err};
        `WCF_OFF_INT_STAT: s_d.rdata = {30'h0, s_q.int_stat};
        `WCF_OFF_INT_MASK: s_d.rdata = {30'h0, s_q.int_mask};
        `WCF_OFF_LAST_CRC: s_d.rdata = {16'h0, s_q.rx_crc, s_q.calc_crc};
        `WCF_OFF_ERR_CNT:  s_d.rdata = {24'h0, s_q.err_cnt};
        default:           s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q          <= '0;
      s_q.st       <= WCF_IDLE;
      s_q.ctrl     <= `WCF_CTRL_RST;
      s_q.int_mask <= `WCF_INT_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // outputs
  assign alert_n_o   = 1'b0;
  assign alert_oe_o  = s_q.alert_cnt != 4'h0;
  assign wr_data_o   = s_q.wr_data;
  assign wr_valid_o  = s_q.wr_valid;
  assign reg_rdata_o = s_q.rdata;
  assign irq_o       = |(s_q.int_stat & s_q.int_mask);

  // ========================================================================
  // checks
  a_alert_pulse_six: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(alert_oe_o) |-> alert_oe_o [*6] ##1 !alert_oe_o || $past(err_ev))
    else $error("alert pulse not six clocks");
  a_alert_on_err: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    err_ev |=> alert_oe_o && !alert_n_o)
    else $error("mismatch did not drive alert");
  a_sticky_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    err_ev |=> s_q.err_clr && s_q.page_err)
    else $error("sticky error bits not set");
  a_sticky_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.err_clr && !(reg_wr_i && reg_addr_i == `WCF_OFF_MODE5) |=> s_q.err_clr)
    else $error("sticky bit fell without a write");
  a_err_cnt_inc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    err_ev |=> s_q.err_cnt == $past(s_q.err_cnt) + 8'h01)
    else $error("error count not incremented");
  a_frame_ten: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.st == WCF_RECV && beat_valid_i && crc_en |=> wr_valid_o == (s_q.beat == 4'ha))
    else $error("checked frame not ten transfers");
  a_no_check_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !crc_en && s_q.st != WCF_CHECK |-> !err_ev ##1 s_q.st != WCF_CHECK)
    else $error("check ran while disabled");
  a_tree_pad_chop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    crc_if.req && s_q.chop |-> crc_if.word[7:4] == 4'hf && crc_if.word[71:68] == 4'hf)
    else $error("chopped padding not ones");
  a_tree_x4_ones: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    crc_if.req && !x8 |-> &crc_if.word[71:32])
    else $error("x4 upper tree inputs not ones");
  a_tree_mask_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    crc_if.req && !mi_en |-> &crc_if.word[71:64])
    else $error("mask lane used while disabled");
  a_read_latency: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == `WCF_OFF_CTRL |=> reg_rdata_o == {29'h0, $past(s_q.ctrl)})
    else $error("register read wrong");

  c_frame_chop: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_valid_o && s_q.chop && crc_en);
  c_frame_full: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_valid_o && !s_q.chop && crc_en);
  c_crc_err: cover property (@(posedge mclk_i) disable iff (!rst_n_i) err_ev);
  c_irq: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule : wcf_framer

// ===== wcf_framer_tb_top.sv
/*
 * self-checking bench of the write checksum framer.
 * assumes: wcf_pkg and wcf_host_model compiled first.
 */
`include "wcf_regs.svh"
module wcf_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wcf_pkg::*;
  logic mclk_i, rst_n_i, reg_wr, reg_rd, bv, fs, mk, bc, hs;
  logic alert_n, alert_oe, wr_valid, irq;
  logic [7:0] dq;
  wcf_addr_t  reg_addr;
  wcf_data_t  reg_wdata, reg_rdata, rd;
  wcf_word_t  wr_data;
  int error_cnt = 0;
  int num_checks = 0;

  wcf_host_model wcf_host_model_inst (
    .beat_valid_o(bv), .frame_start_o(fs), .dq_o(dq), .mask_inv_lane_n_o(mk),
    .burst_chop_four_o(bc), .burst_half_select_o(hs), .mclk_i(mclk_i));

  wcf_framer wcf_framer_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .beat_valid_i(bv), .frame_start_i(fs),
    .dq_i(dq), .mask_inv_lane_n_i(mk), .burst_chop_four_i(bc),
    .burst_half_select_i(hs), .alert_n_o(alert_n), .alert_oe_o(alert_oe),
    .wr_data_o(wr_data), .wr_valid_o(wr_valid), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .irq_o(irq));

  // ==========================================================================
  // clock and watchdog
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    report_and_stop();
  end

  // ==========================================================================
  // shared tasks
  task automatic check_val(input logic [71:0] got, input logic [71:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_val

  task automatic reg_write(input wcf_addr_t a, input wcf_data_t d);
    @(posedge mclk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input wcf_addr_t a, output wcf_data_t d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata;
  endtask : reg_read

  // sends a frame, checks code word and alert pulse length
  task automatic run_frame(input wcf_word_t raw, input logic [4:0] m, input logic bad,
                           input int alert_len);
    int n;
    int w;
    reg_write(`WCF_OFF_CTRL, {29'h0, m[3], m[0], m[4]});
    wcf_host_model_inst.send_frame(raw, m[0], m[1], m[2], m[3], m[4], bad);
    w = 0;
    while (wr_valid !== 1'b1 && w < 4) begin
      @(negedge mclk_i);
      w++;
    end
    check_val(wr_valid, 1'b1, "frame done");
    check_val(wr_data, wcf_host_model_inst.exp_word, "code word");
    n = 0;
    repeat (12) begin
      @(negedge mclk_i);
      n += (alert_oe === 1'b1 && alert_n === 1'b0);
    end
    check_val(n, alert_len, "alert length");
    if (m[4]) begin
      reg_read(`WCF_OFF_LAST_CRC, rd);
      check_val(rd, {16'h0, wcf_host_model_inst.sent_crc, wcf_host_model_inst.exp_crc},
                "checksum");
    end
  endtask : run_frame

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // tests
  initial begin
    rst_n_i   = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    reg_read(`WCF_OFF_CTRL, rd);
    check_val(rd, 32'h0, "ctrl reset");
    reg_read(`WCF_OFF_INT_MASK, rd);
    check_val(rd, 32'h0, "mask reset");
    reg_read(8'h20, rd);
    check_val(rd, 32'h0, "unmapped");
    // all organisations, burst kinds, halves, mask use
    for (int k = 0; k < 16; k++) begin
      run_frame({9{8'h3c ^ k[7:0]}} ^ 72'h5a_0f1e2d3c4b5a6978, {1'b1, k[3:0]}, 1'b0, 0);
    end
    run_frame({9{8'h96}}, 5'h01, 1'b0, 0);
    run_frame({9{8'h96}}, 5'h03, 1'b1, 0);
    @(negedge mclk_i);
    check_val(irq, 1'b0, "masked irq");
    reg_write(`WCF_OFF_INT_MASK, 32'h1);
    run_frame({9{8'ha5}}, 5'h13, 1'b1, 6);
    check_val(irq, 1'b1, "irq on error");
    reg_read(`WCF_OFF_MODE5, rd);
    check_val(rd[3], 1'b1, "sticky bit");
    reg_read(`WCF_OFF_PAGE3, rd);
    check_val(rd[0], 1'b1, "page status");
    reg_read(`WCF_OFF_INT_STAT, rd);
    check_val(rd, 32'h3, "int status");
    reg_read(`WCF_OFF_ERR_CNT, rd);
    check_val(rd, 32'h1, "error count");
    reg_write(`WCF_OFF_INT_STAT, 32'h1);
    @(negedge mclk_i);
    check_val(irq, 1'b0, "irq cleared");
    run_frame({9{8'h0f}}, 5'h1a, 1'b1, 6);
    reg_write(`WCF_OFF_MODE5, 32'h0);
    reg_read(`WCF_OFF_MODE5, rd);
    check_val(rd[3], 1'b0, "sticky clear");
    reg_read(`WCF_OFF_PAGE3, rd);
    check_val(rd[0], 1'b0, "page clear");
    reg_write(`WCF_OFF_ERR_CNT, 32'h0);
    reg_read(`WCF_OFF_ERR_CNT, rd);
    check_val(rd, 32'h0, "count clear");
    reg_write(`WCF_OFF_INT_MASK, 32'h2);
    @(negedge mclk_i);
    check_val(irq, 1'b1, "frame irq");
    reg_write(`WCF_OFF_INT_STAT, 32'h2);
    @(negedge mclk_i);
    check_val(irq, 1'b0, "frame irq cleared");
    report_and_stop();
  end
endmodule : wcf_framer_tb_top

// ===== wcf_host_model.sv
/*
 * controller-side model: builds checked and unchecked write frames.
 * assumes: shares mclk_i with the framer; caller spaces the frames.
 */
module wcf_host_model (
  output logic       beat_valid_o,        // transfer valid
  output logic       frame_start_o,       // transfer 0
  output logic [7:0] dq_o,                // data lanes
  output logic       mask_inv_lane_n_o,   // mask/inversion lane
  output logic       burst_chop_four_o,   // chopped burst
  output logic       burst_half_select_o, // upper half
  input  wire logic  mclk_i               // clock
);
  timeunit 1ns;
  timeprecision 1ps;
  import wcf_pkg::*;
  wcf_word_t exp_word;
  wcf_crc_t  exp_crc;
  wcf_crc_t  sent_crc;

  initial begin
    beat_valid_o        = 1'b0;
    frame_start_o       = 1'b0;
    dq_o                = 8'h00;
    mask_inv_lane_n_o   = 1'b0;
    burst_chop_four_o   = 1'b0;
    burst_half_select_o = 1'b0;
  end

  // ==========================================================================
  // checksum, bit 0 first
  function automatic wcf_crc_t crc8(input wcf_word_t w);
    wcf_crc_t c;
    logic     fb;
    c = 8'h00;
    for (int i = 0; i < 72; i++) begin
      fb = c[7] ^ w[i];
      c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8

  // ==========================================================================
  // frame builder
  task automatic send_frame(input wcf_word_t raw, input logic x8, input logic chop,
                            input logic half, input logic mi, input logic en,
                            input logic bad);
    logic [7:0] b;
    int         nb;
    for (int l = 0; l < 9; l++) begin
      for (int t = 0; t < 8; t++) begin
        exp_word[l*8+t] = (chop && t >= 4) || (!x8 && l >= 4) || (l == 8 && !mi) ?
                          1'b1 : raw[l*8+t];
      end
    end
    exp_crc  = crc8(exp_word);
    sent_crc = exp_crc ^ (bad ? 8'h01 : 8'h00);
    nb       = en ? 10 : (chop ? 4 : 8);
    for (int t = 0; t < nb; t++) begin
      for (int l = 0; l < 8; l++) begin
        b[l] = (t < 8) ? exp_word[l*8+t] : 1'b1;
      end
      @(posedge mclk_i);
      beat_valid_o        <= 1'b1;
      frame_start_o       <= (t == 0);
      burst_chop_four_o   <= chop;
      burst_half_select_o <= half;
      mask_inv_lane_n_o   <= (t < 8) ? exp_word[64+t] : 1'b1;
      if (t == 8) begin
        dq_o <= x8 ? sent_crc : {4'hf, sent_crc[3:0]};
      end else if (t == 9) begin
        dq_o <= x8 ? 8'hff : {4'hf, sent_crc[7:4]};
      end else begin
        dq_o <= b;
      end
    end
    @(posedge mclk_i);
    beat_valid_o      <= 1'b0;
    frame_start_o     <= 1'b0;
    dq_o              <= ~dq_o;
    mask_inv_lane_n_o <= ~mask_inv_lane_n_o;
  endtask : send_frame
endmodule : wcf_host_model

// ===== wcf_pkg.sv
/*
 * types shared by the write checksum framer modules.
 * assumes: wcf_regs.svh is on the include path.
 */
package wcf_pkg;
  `include "wcf_regs.svh"

  typedef logic [71:0] wcf_word_t;
  typedef logic [7:0]  wcf_crc_t;
  typedef logic [7:0]  wcf_addr_t;
  typedef logic [31:0] wcf_data_t;

  typedef enum logic [1:0] {
    WCF_IDLE  = 2'b00,
    WCF_RECV  = 2'b01,
    WCF_CHECK = 2'b10
  } wcf_state_e;
endpackage : wcf_pkg

// ===== wcf_regs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * write checksum framer.
 * assumes: included by bare name from the package and the design modules.
 */
`ifndef WCF_REGS_SVH
`define WCF_REGS_SVH

// ==========================================================================
// register offsets (byte addresses, one word each)
`define WCF_OFF_CTRL      8'h00
`define WCF_OFF_MODE5     8'h04
`define WCF_OFF_PAGE3     8'h08
`define WCF_OFF_INT_STAT  8'h0c
`define WCF_OFF_INT_MASK  8'h10
`define WCF_OFF_LAST_CRC  8'h14
`define WCF_OFF_ERR_CNT   8'h18

// ==========================================================================
// field positions
`define WCF_CTRL_CRC_EN   0
`define WCF_CTRL_ORG_X8   1
`define WCF_CTRL_MI_EN    2
`define WCF_MODE5_ERR_CLR 3
`define WCF_PAGE3_ERR     0
`define WCF_INT_CRC_ERR   0
`define WCF_INT_FRAME     1

// ==========================================================================
// reset values
`define WCF_CTRL_RST      3'h0
`define WCF_INT_MASK_RST  2'h0

// ==========================================================================
// frame and timing figures
`define WCF_CLK_PERIOD_NS 25
`define WCF_FRAME_UI      10
`define WCF_FULL_BEATS    8
`define WCF_CHOP_BEATS    4
`define WCF_ALERT_PW_CLK  6
`define WCF_ALERT_LAT_NS  13
`define WCF_ALERT_LAT_CLK \
  ((`WCF_ALERT_LAT_NS / `WCF_CLK_PERIOD_NS) < 1 ? 1 : (`WCF_ALERT_LAT_NS / `WCF_CLK_PERIOD_NS))
`define WCF_CRC_POLY      8'h07

`endif
